//--- verilog/bbbe_pkg.sv
// Purpose: shared constants for the bit-field / bit-clear / branch execute unit
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
package bbbe_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_INSTR = 8'h04;
  localparam logic [7:0] A_OPN = 8'h08;
  localparam logic [7:0] A_OPM = 8'h0c;
  localparam logic [7:0] A_OPD = 8'h10;
  localparam logic [7:0] A_PC = 8'h14;
  localparam logic [7:0] A_FLAGS = 8'h18;
  localparam logic [7:0] A_RESULT = 8'h1c;
  localparam logic [7:0] A_XSTAT = 8'h20;
  localparam logic [7:0] A_LINK = 8'h24;
  localparam logic [7:0] A_NEXT_PC = 8'h28;
  localparam logic [7:0] A_IRQ_STAT = 8'h2c;
  localparam logic [7:0] A_IRQ_MASK = 8'h30;

  // ****************************************
  // control fields
  // ****************************************
  localparam int CTRL_GO = 0;
  localparam int CTRL_COND_PASS = 1;
  localparam int CTRL_IN_IT = 2;
  localparam int CTRL_LAST_IT = 3;
  localparam int CTRL_HALT_SEL = 4;
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RST = 5'h02;

  // flags nibble: n z c v
  localparam int FL_N = 3;
  localparam int FL_Z = 2;
  localparam int FL_C = 1;
  localparam int FL_V = 0;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // execution status: flags[3:0] dest[7:4] dest_we[8] lr_we[9] branch[10] kind[14:12]
  localparam int XS_DEST_WE = 8;
  localparam int XS_LR_WE = 9;
  localparam int XS_BRANCH = 10;

  // ****************************************
  // events
  // ****************************************
  localparam int EV_DONE = 0;
  localparam int EV_UNPRED = 1;
  localparam int EV_MONITOR = 2;
  localparam int EV_HALT = 3;
  localparam int EV_UNKNOWN = 4;
  localparam int EV_W = 5;
  localparam logic [4:0] EV_RST = 5'h00;

  // ****************************************
  // encodings (first halfword in [31:16])
  // ****************************************
  localparam logic [15:0] FLD_MASK = 16'hfbf0;
  localparam logic [15:0] FLD_MATCH = 16'hf360;
  localparam logic [15:0] BICI_MASK = 16'hfbe0;
  localparam logic [15:0] BICI_MATCH = 16'hf020;
  localparam logic [15:0] BICW_MASK = 16'hffe0;
  localparam logic [15:0] BICW_MATCH = 16'hea20;
  localparam logic [15:0] BICN_MASK = 16'hffc0;
  localparam logic [15:0] BICN_MATCH = 16'h4380;
  localparam logic [15:0] DBG_MASK = 16'hff00;
  localparam logic [15:0] DBG_MATCH = 16'hbe00;
  localparam logic [15:0] CALL1_MASK = 16'hf800;
  localparam logic [15:0] CALL1_MATCH = 16'hf000;
  localparam logic [15:0] CALL2_MASK = 16'hd000;
  localparam logic [15:0] CALL2_MATCH = 16'hd000;
  localparam logic [3:0] REG_SP = 4'hd;
  localparam logic [3:0] REG_PC = 4'hf;
  localparam logic [31:0] STEP16 = 32'h0000_0002;

  // shift kinds
  localparam logic [2:0] SR_LSL = 3'h0;
  localparam logic [2:0] SR_LSR = 3'h1;
  localparam logic [2:0] SR_ASR = 3'h2;
  localparam logic [2:0] SR_ROR = 3'h3;
  localparam logic [2:0] SR_RRX = 3'h4;

  typedef enum logic [2:0] {
    K_NONE, K_FZERO, K_FINS, K_ANDN_IMM, K_ANDN_R16, K_ANDN_R32, K_DSTOP, K_CALL
  } bbbe_kind_e;

endpackage

//--- verilog/bbbe_exec.sv
// Purpose: decode and execute of field zero/insert, and-not, debug stop and relative call
// Assumes: software loads operand values and program counter, then writes go
// Notes: apb slave answers with no wait state; unpredictable cases write nothing

// Notes on behaviour
// - field zero clears bits lsb..msb when msb >= lsb; inverted pair is unpredictable
// - field insert with source 1111 becomes field zero; lsb from imm3:imm2, msb field
// - field insert with destination 13 or 15, or source 13, is unpredictable
// - field insert copies low msb-lsb+1 source bits into lsb..msb, others kept
// - and-not immediate sets flags when S is one; expands i:imm3:imm8 with carry
// - and-not immediate with destination or first operand 13 or 15 is unpredictable
// - and-not immediate writes n and not constant; N, Z, C updated, V kept
// - 16-bit and-not: one field is dest and operand, no shift, flags outside block
// - 32-bit and-not decodes shift from type and imm3:imm2; regs 13/15 unpredictable
// - register and-not shifts second operand with carry, writes n and not shifted
// - debug stop raises monitor trap or debug halt per debug configuration
// - debug stop executes regardless of condition, inside or outside a block
// - debug stop immediate is ignored by hardware
// - call offset from S, inverted J xor S, imm10, imm11, zero, sign-extended
// - call inside a block but not last is unpredictable
// - call loads link with next address bit0 set, branches to pc plus offset
module bbbe_exec
  import bbbe_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // debug events and interrupt
  output logic monitor_trap_exception,
  output logic debug_halt,
  output logic irq
);

  // ****************************************
  // state
  // ****************************************
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [CTRL_W-1:1] ctrl_q;
  logic exec_go_q;
  logic [31:0] instr_q;
  logic [31:0] opn_q;
  logic [31:0] opm_q;
  logic [31:0] opd_q;
  logic [31:0] pc_q;
  logic [3:0] program_status_flags_q;
  logic [31:0] result_q;
  logic [14:0] xstat_q;
  logic [31:0] link_q;
  logic [31:0] next_pc_q;
  logic [EV_W-1:0] irq_stat_q;
  logic [EV_W-1:0] irq_mask_q;
  logic irq_q;
  logic monitor_trap_q;
  logic debug_halt_q;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign monitor_trap_exception = monitor_trap_q;
  assign debug_halt = debug_halt_q;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [32:0] shift_c(input logic [31:0] v, input logic [2:0] t,
                                          input logic [5:0] n, input logic ci);
    logic [32:0] tmp;
    logic [31:0] r;
    tmp = 33'h0;
    r = 32'h0;
    if (n == 6'h00)
      return {ci, v};
    case (t)
      SR_LSL:
      begin
        tmp = {1'b0, v} << n;
        return tmp;
      end
      SR_LSR:
      begin
        tmp = {v, 1'b0} >> n;
        return {tmp[0], tmp[32:1]};
      end
      SR_ASR:
      begin
        tmp = $signed({v, 1'b0}) >>> n;
        return {tmp[0], tmp[32:1]};
      end
      SR_ROR:
      begin
        r = (v >> n[4:0]) | (v << (6'h20 - n));
        return {r[31], r};
      end
      SR_RRX:
        return {v[0], ci, v[31:1]};
      default:
        return {ci, v};
    endcase
  endfunction

  // expand_c: modified 12-bit immediate to 32-bit constant plus carry
  function automatic logic [32:0] expand_c(input logic [11:0] imm12, input logic ci);
    logic [7:0] b;
    logic [31:0] unrot;
    logic [31:0] r;
    b = imm12[7:0];
    unrot = {24'h0, 1'b1, imm12[6:0]};
    r = 32'h0;
    if (imm12[11:10] == 2'h0)
    begin
      case (imm12[9:8])
        2'h0: r = {24'h0, b};
        2'h1: r = {8'h0, b, 8'h0, b};
        2'h2: r = {b, 8'h0, b, 8'h0};
        default: r = {b, b, b, b};
      endcase
      return {ci, r};
    end
    r = (unrot >> imm12[11:7]) | (unrot << (6'h20 - {1'b0, imm12[11:7]}));
    return {r[31], r};
  endfunction

  // ****************************************
  // decode
  // ****************************************
  logic [15:0] hw1;
  logic [15:0] hw2;
  bbbe_kind_e kind;
  logic [4:0] lsb;
  logic [4:0] msb;
  logic [3:0] rn;
  logic [3:0] rd32;
  logic [3:0] rm32;
  logic [4:0] imm5;
  logic [31:0] fmask;
  logic [31:0] call_off;
  logic s_bit;
  logic i1;
  logic i2;

  assign hw1 = instr_q[31:16];
  assign hw2 = instr_q[15:0];
  assign rn = hw1[3:0];
  assign rd32 = hw2[11:8];
  assign rm32 = hw2[3:0];
  assign lsb = {hw2[14:12], hw2[7:6]};
  assign msb = hw2[4:0];
  assign imm5 = {hw2[14:12], hw2[7:6]};
  assign fmask = (32'hffff_ffff << lsb) & (32'hffff_ffff >> (5'h1f - msb));
  assign s_bit = hw1[10];
  assign i1 = ~(hw2[13] ^ s_bit);
  assign i2 = ~(hw2[11] ^ s_bit);
  assign call_off = {{7{s_bit}}, s_bit, i1, i2, hw1[9:0], hw2[10:0], 1'b0};

  always_comb
  begin
    kind = K_NONE;
    if ((hw1 & FLD_MASK) == FLD_MATCH && !hw2[15])
      kind = (rn == 4'hf) ? K_FZERO : K_FINS;
    else if ((hw1 & BICI_MASK) == BICI_MATCH && !hw2[15])
      kind = K_ANDN_IMM;
    else if ((hw1 & BICW_MASK) == BICW_MATCH)
      kind = K_ANDN_R32;
    else if ((hw1 & BICN_MASK) == BICN_MATCH)
      kind = K_ANDN_R16;
    else if ((hw1 & DBG_MASK) == DBG_MATCH)
      kind = K_DSTOP; // imm8 unused
    else if ((hw1 & CALL1_MASK) == CALL1_MATCH && (hw2 & CALL2_MASK) == CALL2_MATCH)
      kind = K_CALL;
  end

  // ****************************************
  // execute
  // ****************************************
  logic [31:0] x_res;
  logic [3:0] x_dest;
  logic x_dest_we;
  logic [3:0] x_flags;
  logic x_flags_we;
  logic x_lr_we;
  logic x_branch;
  logic [31:0] x_next_pc;
  logic x_unpred;
  logic x_unknown;
  logic x_stop;
  logic [32:0] x_cr;
  logic [2:0] sh_t;
  logic [5:0] sh_n;
  logic is16;
  logic cond_ok;

  assign is16 = (kind == K_ANDN_R16) || (kind == K_DSTOP) || (kind == K_NONE && hw1[15:11] < 5'h1d);
  assign cond_ok = ctrl_q[CTRL_COND_PASS];

  // shift decode from type and imm3:imm2
  always_comb
  begin
    sh_t = SR_LSL;
    sh_n = {1'b0, imm5};
    case (hw2[5:4])
      2'h0: sh_t = SR_LSL;
      2'h1:
      begin
        sh_t = SR_LSR;
        sh_n = (imm5 == 5'h0) ? 6'h20 : {1'b0, imm5};
      end
      2'h2:
      begin
        sh_t = SR_ASR;
        sh_n = (imm5 == 5'h0) ? 6'h20 : {1'b0, imm5};
      end
      default:
      begin
        sh_t = (imm5 == 5'h0) ? SR_RRX : SR_ROR;
        sh_n = (imm5 == 5'h0) ? 6'h01 : {1'b0, imm5};
      end
    endcase
  end

  always_comb
  begin
    x_res = opd_q;
    x_dest = rd32;
    x_dest_we = 1'b0;
    x_flags = program_status_flags_q;
    x_flags_we = 1'b0;
    x_lr_we = 1'b0;
    x_branch = 1'b0;
    x_next_pc = is16 ? pc_q - STEP16 : pc_q;
    x_unpred = 1'b0;
    x_unknown = 1'b0;
    x_stop = 1'b0;
    x_cr = 33'h0;
    case (kind)
      K_FZERO:
      begin
        x_unpred = (rd32 == REG_SP) || (rd32 == REG_PC) || (msb < lsb);
        x_res = opd_q & ~fmask;
        x_dest_we = 1'b1;
      end
      K_FINS:
      begin
        x_unpred = (rd32 == REG_SP) || (rd32 == REG_PC) || (rn == REG_SP) || (msb < lsb);
        x_res = (opd_q & ~fmask) | ((opn_q << lsb) & fmask);
        x_dest_we = 1'b1;
      end
      K_ANDN_IMM:
      begin
        x_unpred = (rd32 == REG_SP) || (rd32 == REG_PC) || (rn == REG_SP) || (rn == REG_PC);
        x_cr = expand_c({hw1[10], hw2[14:12], hw2[7:0]}, program_status_flags_q[FL_C]);
        x_res = opn_q & ~x_cr[31:0];
        x_dest_we = 1'b1;
        x_flags_we = hw1[4];
      end
      K_ANDN_R16:
      begin
        x_dest = {1'b0, hw1[2:0]};
        x_cr = {program_status_flags_q[FL_C], opm_q};
        x_res = opn_q & ~x_cr[31:0];
        x_dest_we = 1'b1;
        x_flags_we = !ctrl_q[CTRL_IN_IT];
      end
      K_ANDN_R32:
      begin
        x_unpred = (rd32 == REG_SP) || (rd32 == REG_PC) || (rn == REG_SP) || (rn == REG_PC)
                   || (rm32 == REG_SP) || (rm32 == REG_PC);
        x_cr = shift_c(opm_q, sh_t, sh_n, program_status_flags_q[FL_C]);
        x_res = opn_q & ~x_cr[31:0];
        x_dest_we = 1'b1;
        x_flags_we = hw1[4];
      end
      K_DSTOP:
        x_stop = 1'b1;
      K_CALL:
      begin
        x_unpred = ctrl_q[CTRL_IN_IT] && !ctrl_q[CTRL_LAST_IT];
        x_lr_we = 1'b1;
        x_branch = 1'b1;
      end
      default:
        x_unknown = 1'b1;
    endcase
    if (x_flags_we)
    begin
      x_flags[FL_N] = x_res[31];
      x_flags[FL_Z] = (x_res == 32'h0);
      x_flags[FL_C] = x_cr[32];
    end
    // failed condition or unpredictable: nothing but the step
    if (kind != K_DSTOP && (!cond_ok || x_unpred))
    begin
      x_dest_we = 1'b0;
      x_flags_we = 1'b0;
      x_flags = program_status_flags_q;
      x_lr_we = 1'b0;
      x_branch = 1'b0;
    end
    if (x_branch)
      x_next_pc = pc_q + call_off;
  end

  // ****************************************
  // apb slave
  // ****************************************
  logic setup;
  logic wr;
  logic mapped;
  logic [EV_W-1:0] ev;

  assign setup = psel && !penable;
  assign wr = psel && penable && pready_q && pwrite && !pslverr_q;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= A_IRQ_MASK);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      if (setup && !pwrite)
      begin
        case (paddr)
          A_CTRL: prdata_q <= {27'h0, ctrl_q, 1'b0};
          A_INSTR: prdata_q <= instr_q;
          A_OPN: prdata_q <= opn_q;
          A_OPM: prdata_q <= opm_q;
          A_OPD: prdata_q <= opd_q;
          A_PC: prdata_q <= pc_q;
          A_FLAGS: prdata_q <= {28'h0, program_status_flags_q};
          A_RESULT: prdata_q <= result_q;
          A_XSTAT: prdata_q <= {17'h0, xstat_q};
          A_LINK: prdata_q <= link_q;
          A_NEXT_PC: prdata_q <= next_pc_q;
          A_IRQ_STAT: prdata_q <= {27'h0, irq_stat_q};
          A_IRQ_MASK: prdata_q <= {27'h0, irq_mask_q};
          default: prdata_q <= 32'h0;
        endcase
      end
      else
        prdata_q <= 32'h0;
    end
  end

  // software-loaded operands and controls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= CTRL_RST[CTRL_W-1:1];
      exec_go_q <= 1'b0;
      instr_q <= 32'h0;
      opn_q <= 32'h0;
      opm_q <= 32'h0;
      opd_q <= 32'h0;
      pc_q <= 32'h0;
      irq_mask_q <= EV_RST;
    end
    else
    begin
      exec_go_q <= wr && (paddr == A_CTRL) && pwdata[CTRL_GO];
      if (wr)
      begin
        case (paddr)
          A_CTRL: ctrl_q <= pwdata[CTRL_W-1:1];
          A_INSTR: instr_q <= pwdata;
          A_OPN: opn_q <= pwdata;
          A_OPM: opm_q <= pwdata;
          A_OPD: opd_q <= pwdata;
          A_PC: pc_q <= pwdata;
          A_IRQ_MASK: irq_mask_q <= pwdata[EV_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // flags: software write, or an executed flag-setting instruction
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      program_status_flags_q <= FLAGS_RST;
    else if (exec_go_q)
      program_status_flags_q <= x_flags;
    else if (wr && paddr == A_FLAGS)
      program_status_flags_q <= pwdata[3:0];
  end

  // ****************************************
  // results
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result_q <= 32'h0;
      xstat_q <= 15'h0;
      link_q <= 32'h0;
      next_pc_q <= 32'h0;
      monitor_trap_q <= 1'b0;
      debug_halt_q <= 1'b0;
    end
    else
    begin
      monitor_trap_q <= exec_go_q && x_stop && !ctrl_q[CTRL_HALT_SEL];
      debug_halt_q <= exec_go_q && x_stop && ctrl_q[CTRL_HALT_SEL];
      if (exec_go_q)
      begin
        if (x_dest_we)
          result_q <= x_res;
        if (x_lr_we)
          link_q <= {pc_q[31:1], 1'b1};
        next_pc_q <= x_next_pc;
        xstat_q <= {kind, 1'b0, x_branch, x_lr_we, x_dest_we, x_dest, x_flags};
      end
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  assign ev = {x_unknown, x_stop && ctrl_q[CTRL_HALT_SEL], x_stop && !ctrl_q[CTRL_HALT_SEL],
               x_unpred && kind != K_DSTOP, 1'b1} & {EV_W{exec_go_q}};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_q <= EV_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~((wr && paddr == A_IRQ_STAT) ? pwdata[EV_W-1:0] : EV_RST)) | ev;
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_fzero_clear:
  assert property (exec_go_q && kind == K_FZERO && cond_ok && !x_unpred
                   |=> result_q == ($past(opd_q) & ~$past(fmask)))
  else $error("field zero result wrong");

  chk_fins_alias:
  assert property (exec_go_q && (hw1 & FLD_MASK) == FLD_MATCH && !hw2[15] && rn == 4'hf
                   |=> xstat_q[14:12] == K_FZERO)
  else $error("source 1111 not treated as field zero");

  chk_fins_unpred:
  assert property (exec_go_q && kind == K_FINS && (rd32 == REG_SP || rn == REG_SP)
                   |=> !xstat_q[XS_DEST_WE] && irq_stat_q[EV_UNPRED])
  else $error("bad field insert register not flagged");

  chk_andn_vkeep:
  assert property (exec_go_q && (kind == K_ANDN_IMM || kind == K_ANDN_R32 || kind == K_ANDN_R16)
                   |=> program_status_flags_q[FL_V] == $past(program_status_flags_q[FL_V]))
  else $error("overflow flag changed by and-not");

  chk_dstop_uncond:
  assert property (exec_go_q && kind == K_DSTOP && !cond_ok |=> monitor_trap_q || debug_halt_q)
  else $error("debug stop skipped on failed condition");

  chk_trap_select:
  assert property (monitor_trap_q |-> !ctrl_q[CTRL_HALT_SEL] && !debug_halt_q ##1 !monitor_trap_q)
  else $error("monitor trap not a single pulse or wrong select");

  chk_call_link:
  assert property (exec_go_q && kind == K_CALL && cond_ok && !x_unpred
                   |=> link_q == {$past(pc_q[31:1]), 1'b1} && next_pc_q[0] == $past(pc_q[0]))
  else $error("call link or target wrong");

  chk_call_unpred:
  assert property (exec_go_q && kind == K_CALL && ctrl_q[CTRL_IN_IT] && !ctrl_q[CTRL_LAST_IT]
                   |=> !xstat_q[XS_LR_WE] && !xstat_q[XS_BRANCH])
  else $error("call inside block not last was executed");

  chk_cond_fail:
  assert property (exec_go_q && !cond_ok && kind != K_DSTOP
                   |=> $stable(result_q) && $stable(link_q) && $stable(program_status_flags_q))
  else $error("state changed on failed condition");

  chk_irq_level:
  assert property (##1 irq_q == |($past(irq_stat_q) & $past(irq_mask_q)))
  else $error("interrupt level does not follow masked status");

endmodule

//--- testbench/bitfield_bitclear_branch_exec_test.sv
// Purpose: self-checking bench for the execute unit
// Assumes: zero-wait apb slave; a go write starts one execution
// Notes: operands from a fixed xorshift seed, corner cases after
module bitfield_bitclear_branch_exec_test
  import bbbe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // signals and design
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, mon, hlt, irq;
  logic [31:0] rd, a, b, c, pc, e, sft, seed = 32'h0000_0058;
  logic err, mon_s, hlt_s, s, j1, j2;
  logic [3:0] f, rdi;
  logic [4:0] lsb, msb, sh;
  logic [7:0] imm8;
  logic [9:0] i10;
  logic [10:0] i11;
  int n_mismatch = 0;
  int cmp_count = 0;

  always #20 pclk = ~pclk;

  bbbe_exec dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .monitor_trap_exception(mon),
    .debug_halt(hlt), .irq(irq)
  );

  // ****************************************
  // helpers
  // ****************************************
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function logic [31:0] fmask(input int l, input int m);
    return 32'(((64'h1 << (m - l + 1)) - 64'h1) << l);
  endfunction

  function logic [31:0] flg(input logic [31:0] r, input logic cy, input logic v);
    return {28'h0, r[31], r == 32'h0, cy, v};
  endfunction

  function logic [31:0] enc_fld(input logic [3:0] rn, input logic [3:0] d, input logic [4:0] l, input logic [4:0] m);
    return {12'hf36, rn, 1'b0, l[4:2], d, l[1:0], 1'b0, m};
  endfunction

  task give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
    begin
      n_mismatch++;
      $display("mismatch at %0t: no ready within bound", $time);
      give_verdict;
    end
    else
    begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task rdchk(input logic [7:0] ad, input logic [31:0] x);
    apb(1'b0, ad, 32'h0);
    chk(rd, x);
  endtask

  task run(input logic [31:0] ins, input logic [31:0] cfg);
    apb(1'b1, A_IRQ_STAT, 32'h1f);
    apb(1'b1, A_INSTR, ins);
    apb(1'b1, A_OPN, a);
    apb(1'b1, A_OPM, b);
    apb(1'b1, A_OPD, c);
    apb(1'b1, A_PC, pc);
    apb(1'b1, A_FLAGS, {28'h0, f});
    apb(1'b1, A_CTRL, cfg | 32'h1);
    @(posedge pclk);
    #1;
    mon_s = mon;
    hlt_s = hlt;
  endtask

  task unp;
    apb(1'b0, A_IRQ_STAT, 32'h0);
    chk({31'h0, rd[EV_UNPRED]}, 32'h1);
  endtask

  task pick;
    a = rnd();
    b = rnd();
    c = rnd();
    pc = rnd() & 32'hffff_fffe;
    f = 4'(rnd());
    rdi = 4'(rnd() % 13);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(A_CTRL, 32'h2);
    rdchk(A_FLAGS, 32'h0);
    rdchk(8'h34, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int k = 0; k < 8; k++)
    begin
      pick;
      lsb = 5'(rnd());
      msb = 5'(lsb + rnd() % (32 - lsb));
      run(enc_fld(4'hf, rdi, lsb, msb), 32'h2);
      rdchk(A_RESULT, c & ~fmask(lsb, msb));
      run(enc_fld(4'h1, rdi, lsb, msb), 32'h2);
      rdchk(A_RESULT, (c & ~fmask(lsb, msb)) | ((a << lsb) & fmask(lsb, msb)));
      imm8 = 8'(rnd());
      run({12'hf03, 4'h1, 1'b0, 3'h0, rdi, imm8}, 32'h2);
      e = a & ~{24'h0, imm8};
      rdchk(A_RESULT, e);
      rdchk(A_FLAGS, flg(e, f[FL_C], f[FL_V]));
      sh = 5'(1 + rnd() % 31);
      sft = b << sh;
      run({12'hea3, 4'h1, 1'b0, sh[4:2], rdi, sh[1:0], 2'b00, 4'h2}, 32'h2);
      e = a & ~sft;
      rdchk(A_RESULT, e);
      rdchk(A_FLAGS, flg(e, b[32 - int'(sh)], f[FL_V]));
      run({10'h10e, 3'h2, 3'h1, 16'h0}, 32'h6);
      rdchk(A_RESULT, a & ~b);
      rdchk(A_FLAGS, {28'h0, f});
      run({10'h10e, 3'h2, 3'h1, 16'h0}, 32'h2);
      rdchk(A_FLAGS, flg(a & ~b, f[FL_C], f[FL_V]));
      {s, j1, j2, i10, i11} = 24'(rnd());
      run({5'h1e, s, i10, 2'b11, j1, 1'b1, j2, i11}, 32'h2);
      e = {{8{s}}, ~(j1 ^ s), ~(j2 ^ s), i10, i11, 1'b0};
      rdchk(A_NEXT_PC, pc + e);
      rdchk(A_LINK, {pc[31:1], 1'b1});
    end
    pick;
    run(enc_fld(4'h1, 4'hd, 5'h0, 5'h7), 32'h2);
    unp;
    run(enc_fld(4'hd, 4'h2, 5'h0, 5'h7), 32'h2);
    unp;
    run(enc_fld(4'hf, 4'h2, 5'h8, 5'h3), 32'h2);
    unp;
    run({12'hf03, 4'hf, 16'h0120}, 32'h2);
    unp;
    run({12'hea2, 4'h1, 16'h010d}, 32'h2);
    unp;
    run(32'hf000_f800, 32'h6);
    unp;
    for (int h = 0; h < 2; h++)
    begin
      run({8'hbe, 8'(rnd()), 16'h0}, 32'(h << CTRL_HALT_SEL));
      chk({31'h0, mon_s}, 32'(1 - h));
      chk({31'h0, hlt_s}, 32'(h));
    end
    apb(1'b0, A_RESULT, 32'h0);
    e = rd;
    run({12'hf03, 4'h1, 16'h0233}, 32'h0);
    rdchk(A_RESULT, e);
    rdchk(A_FLAGS, {28'h0, f});
    rdchk(A_NEXT_PC, pc);
    run(32'hf000_f800, 32'h6);
    apb(1'b1, A_IRQ_MASK, 32'h2);
    repeat (2) @(posedge pclk);
    #1;
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, A_IRQ_STAT, 32'h2);
    repeat (2) @(posedge pclk);
    #1;
    chk({31'h0, irq}, 32'h0);
    give_verdict;
  end
endmodule
